// ==== host_model.sv ====
// Host-side model that drives the module's pins and lane states.
`timescale 1ns/1ns
`include "msm_defs.svh"
module host_model #(
  parameter int RESET_PULSE_CYC = 8
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Commands from the bench.
  input wire logic reset_go,
  input wire logic supply_low,
  input wire logic lp_pin,
  input wire logic lanes_up,
  // Wires to the module.
  output msm_pkg::host_pins_s pins,
  output logic [4*`LANES-1:0] lane_path_state
);
  import msm_pkg::*;
  logic [7:0] pulse_cnt;
  // A reset request keeps the pin asserted for a whole minimum pulse.
  always_ff @(posedge aclk) begin
    if (!aresetn) pulse_cnt <= 8'h00;
    else if (reset_go) pulse_cnt <= 8'(RESET_PULSE_CYC);
    else if (pulse_cnt != 8'h00) pulse_cnt <= pulse_cnt - 8'h01;
  end
  // Pins and lanes follow the bench commands one cycle later.
  always_ff @(posedge aclk) begin
    pins.supply_low_reset <= supply_low;
    pins.host_reset <= reset_go || pulse_cnt != 8'h00;
    pins.hw_low_power_request_pin <= lp_pin;
    lane_path_state <= lanes_up ? {`LANES{4'h4}} : {`LANES{`PATH_DEACT}};
  end
endmodule : host_model

// ==== module_state_machine.sv ====
// Module state machine with an AXI4-Lite register slave.
// Function
// - Flag on entry to fault, low power, ready.
// - No flag when exit already true.
// - Start in reset, leave when reset clears.
// - Priority reset, then fault, then others.
// - Reset is supply, pin or soft bit.
// - Missing supply monitor reads as deasserted.
// - Low power is sw bit or allowed pin.
// - Exit needs low power and paths deactivated.
// - Fault condition defined by implementation.
// - Resetting holds all in reset, then reset.
// - Reset state keeps everything reset, low power.
// - Init goes resetting, fault or low power.
// - Low power: memory open, up when clear.
// - Power up goes down or to ready.
// - Ready leaves only on low power exit.
// - Power down returns to low power state.
// - Fault leaves only for resetting.
// - Low power mode in reset, init, lowpower.
// - Fault state kept in low power.
// - Transitions never clear the flag.
// - Reset condition forces resetting except reset.
// - Soft reset bit cleared entering reset.
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "msm_defs.svh"
module module_state_machine (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Host pins, asynchronous to aclk.
  input wire msm_pkg::host_pins_s pins,
  // Data path states, one nibble per host lane.
  input wire logic [4*`LANES-1:0] lane_path_state,
  input wire logic internal_fault,
  // AXI4-Lite write address and data.
  input wire logic [4:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read.
  input wire logic [4:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Module outputs.
  output msm_pkg::power_ctl_s power_ctl,
  output logic irq
);
  import msm_pkg::*;

  msm_state_e state;
  msm_state_e next_state;
  host_pins_s pins_meta;
  host_pins_s pins_sync;
  logic [3:0] control;
  logic state_change_flag;
  logic flag_mask;
  logic [7:0] timer;
  logic reset_cond;
  logic fault_cond;
  logic low_power_cond;
  logic low_power_exit_cond;
  logic all_paths_deactivated;
  logic [`LANES-1:0] lane_deact;
  logic timer_done;
  logic exit_now;
  logic [7:0] next_timer;
  logic aw_held;
  logic w_held;
  logic [4:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic do_write;
  logic flag_rd_clear;

  //////////////////////////////////////////////////////////////////////////
  // Two-stage synchroniser for the host pins and the supply monitor.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins_meta <= '0;
      pins_sync <= '0;
    end else begin
      pins_meta <= pins;
      pins_sync <= pins_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Transition signals; an unconnected monitor is tied low outside.
  generate
    for (genvar i = 0; i < `LANES; i++) begin : g_lane
      assign lane_deact[i] = (lane_path_state[4*i +: 4] == `PATH_DEACT);
    end
  endgenerate
  assign all_paths_deactivated = &lane_deact;
  assign reset_cond = pins_sync.supply_low_reset | pins_sync.host_reset
                    | control[`BIT_SOFT_RESET];
  assign fault_cond = internal_fault | control[`BIT_FAULT_INJECT];
  assign low_power_cond = control[`BIT_SW_LP_REQ]
    | (control[`BIT_HW_LP_ALLOW] & pins_sync.hw_low_power_request_pin);
  assign low_power_exit_cond = low_power_cond & all_paths_deactivated;
  assign timer_done = (timer == 8'h00);

  //////////////////////////////////////////////////////////////////////////
  // Next state with reset first, fault second, others last.
  // Resetting always runs to its end, even while the reset condition
  // holds, so that a held condition parks the machine in the reset state.
  always_comb begin
    next_state = state;
    next_timer = (timer == 8'h00) ? 8'h00 : timer - 8'h01;
    if (reset_cond && state != st_reset && state != st_resetting) begin
      next_state = st_resetting;
      next_timer = 8'(`RESETTING_CYC);
    end else if (fault_cond && state != st_resetting && state != st_reset
                 && state != fault_state) begin
      next_state = fault_state;
    end else begin
      unique case (state)
        st_resetting: if (timer_done) next_state = st_reset;
        st_reset: if (!reset_cond) begin
          next_state = management_init_state;
          next_timer = 8'(`MGMT_INIT_CYC);
        end
        management_init_state:
          if (timer_done) next_state = low_power_state;
        low_power_state: if (!low_power_cond) begin
          next_state = power_up_state;
          next_timer = 8'(`PWR_UP_CYC);
        end
        power_up_state: if (low_power_cond) begin
          next_state = power_down_state;
          next_timer = 8'(`PWR_DN_CYC);
        end else if (timer_done) next_state = ready_state;
        ready_state: if (low_power_exit_cond) begin
          next_state = power_down_state;
          next_timer = 8'(`PWR_DN_CYC);
        end
        power_down_state:
          if (timer_done) next_state = low_power_state;
        fault_state: next_state = fault_state;
      endcase
    end
  end

  // State register; reset starts in the reset state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= st_reset;
      timer <= 8'h00;
    end else begin
      state <= next_state;
      timer <= next_timer;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Exit already true on the entry cycle suppresses the flag.
  always_comb begin
    exit_now = reset_cond | fault_cond;
    unique case (next_state)
      low_power_state: exit_now = exit_now | !low_power_cond;
      ready_state: exit_now = exit_now | low_power_exit_cond;
      fault_state: exit_now = reset_cond;
      default: exit_now = 1'b1;
    endcase
  end

  // Sticky flag; set wins over the read clear, transitions never clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_change_flag <= 1'b0;
    end else if (next_state != state && !exit_now) begin
      state_change_flag <= 1'b1;
    end else if (flag_rd_clear) begin
      state_change_flag <= 1'b0;
    end
  end

  // Interrupt follows the flag unless masked, quiet in reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) irq <= 1'b0;
    else irq <= state_change_flag & !flag_mask & (state != st_reset);
  end

  // Power controls derived from the state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_ctl <= '{in_reset: 1'b1, high_power_allowed: 1'b0,
                     mem_accessible: 1'b0};
    end else begin
      power_ctl.in_reset <= (state == st_resetting) | (state == st_reset);
      power_ctl.high_power_allowed <= (state == power_up_state)
        | (state == ready_state) | (state == power_down_state);
      power_ctl.mem_accessible <= (state != st_resetting)
        & (state != st_reset) & (state != management_init_state);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Write channel capture; address and data taken in either order.
  assign do_write = aw_held & w_held & !bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= 5'h00;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= 2'h0;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr_q <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
        wready <= 1'b0;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (aw_addr_q == `OFS_CONTROL || aw_addr_q == `OFS_MASK)
                 ? 2'h0 : 2'h2;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Control and mask registers; soft reset self-clears in reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control <= `CONTROL_RESET;
      flag_mask <= `MASK_RESET;
    end else begin
      if (do_write && w_strb_q[0] && aw_addr_q == `OFS_CONTROL)
        control <= w_data_q[3:0];
      if (do_write && w_strb_q[0] && aw_addr_q == `OFS_MASK)
        flag_mask <= w_data_q[0];
      if (state == st_resetting && next_state == st_reset)
        control[`BIT_SOFT_RESET] <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read channel; flags clear when read.
  assign flag_rd_clear = arvalid & arready & (araddr == `OFS_FLAGS);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= 2'h0;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= 2'h0;
      unique case (araddr)
        `OFS_CONTROL: rdata <= {28'h0, control};
        `OFS_STATUS: rdata <= {29'h0, state};
        `OFS_FLAGS: rdata <= {31'h0, state_change_flag};
        `OFS_MASK: rdata <= {31'h0, flag_mask};
        `OFS_PATHS: rdata <= {31'h0, all_paths_deactivated};
        default: begin
          rdata <= 32'h0;
          rresp <= 2'h2;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks on the state machine.
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  reset_to_resetting_a: assert property (
    reset_cond && !(state inside {st_reset, st_resetting})
    |=> state == st_resetting)
    else $error("reset condition did not force resetting");
  reset_hold_a: assert property (
    state == st_reset && reset_cond |=> state == st_reset)
    else $error("left reset while reset condition true");
  fault_priority_a: assert property (
    !reset_cond && fault_cond && state == ready_state
    |=> state == fault_state)
    else $error("fault not taken from ready");
  fault_stays_a: assert property (
    state == fault_state && !reset_cond |=> state == fault_state)
    else $error("fault left without reset");
  ready_exit_a: assert property (
    state == ready_state && !reset_cond && !fault_cond
    && !low_power_exit_cond |=> state == ready_state)
    else $error("ready left without exit condition");
  flag_set_a: assert property (
    $changed(state) && state inside {st_resetting, st_reset,
    management_init_state, power_up_state, power_down_state}
    && !$past(state_change_flag) && !$past(flag_rd_clear)
    |-> !state_change_flag)
    else $error("flag set on unflagged state");
  lp_cond_a: assert property (
    control[`BIT_SW_LP_REQ] |-> low_power_cond)
    else $error("low power condition wrong");
  softreset_clear_a: assert property (
    state == st_resetting && next_state == st_reset
    |=> !control[`BIT_SOFT_RESET])
    else $error("soft reset bit not cleared");
  resetting_done_a: assert property (
    $rose(state == st_resetting) |-> ##[1:12] state != st_resetting)
    else $error("resetting too long");
  lp_mode_a: assert property (
    state inside {st_reset, management_init_state, low_power_state}
    |=> !power_ctl.high_power_allowed)
    else $error("high power in low power state");

  ready_seen_c: cover property (state == power_up_state ##1
                                state == ready_state);
  down_seen_c: cover property (state == power_down_state ##1
                               state == low_power_state);
  fault_seen_c: cover property ($rose(state == fault_state));
  irq_seen_c: cover property ($rose(irq));
endmodule : module_state_machine

// ==== msm_defs.svh ====
// Register offsets, reset values and timing counts for the module state machine.
`ifndef MSM_DEFS_SVH
`define MSM_DEFS_SVH
`define OFS_CONTROL 5'h00
`define OFS_STATUS 5'h04
`define OFS_FLAGS 5'h08
`define OFS_MASK 5'h0C
`define OFS_PATHS 5'h10
`define BIT_SOFT_RESET 0
`define BIT_SW_LP_REQ 1
`define BIT_HW_LP_ALLOW 2
`define BIT_FAULT_INJECT 3
`define CONTROL_RESET 4'h4
`define MASK_RESET 1'b0
`define RESETTING_NS 400
`define RESETTING_CYC ((`RESETTING_NS + 39) / 40)
`define MGMT_INIT_NS 800
`define MGMT_INIT_CYC ((`MGMT_INIT_NS + 39) / 40)
`define PWR_UP_NS 1200
`define PWR_UP_CYC ((`PWR_UP_NS + 39) / 40)
`define PWR_DN_NS 800
`define PWR_DN_CYC ((`PWR_DN_NS + 39) / 40)
`define LANES 8
`define PATH_DEACT 4'h1
`endif

// ==== msm_pkg.sv ====
// Types shared by the module state machine and its bench.
package msm_pkg;
  typedef enum logic [2:0] {
    st_resetting, st_reset, management_init_state, low_power_state,
    power_up_state, ready_state, power_down_state, fault_state
  } msm_state_e;
  typedef struct packed {
    logic supply_low_reset;
    logic host_reset;
    logic hw_low_power_request_pin;
  } host_pins_s;
  typedef struct packed {
    logic in_reset;
    logic high_power_allowed;
    logic mem_accessible;
  } power_ctl_s;
  typedef logic [31:0] word_t;
endpackage : msm_pkg

// ==== tb_top.sv ====
// Self-checking bench for the module state machine.
`timescale 1ns/1ns
`include "msm_defs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  num_errors++; \
  $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  import msm_pkg::*;
  logic aclk, aresetn, reset_go, supply_low, lp_pin, lanes_up, fault;
  logic [4:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [3:0] wstrb;
  word_t wdata, rdata;
  host_pins_s pins;
  logic [4*`LANES-1:0] lanes;
  power_ctl_s power_ctl;
  int num_errors = 0;
  int checks_done = 0;
  logic [1:0] last_bresp;
  ////////////////////////////////////////////////////////////////////////
  host_model host (.aclk(aclk), .aresetn(aresetn), .reset_go(reset_go),
    .supply_low(supply_low), .lp_pin(lp_pin), .lanes_up(lanes_up),
    .pins(pins), .lane_path_state(lanes));
  module_state_machine uut (.aclk(aclk), .aresetn(aresetn), .pins(pins),
    .lane_path_state(lanes), .internal_fault(fault), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .power_ctl(power_ctl), .irq(irq));
  // The clock runs at 25 MHz.
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  // Waits a number of clock cycles.
  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask : idle
  // One AXI4-Lite write, waiting for the response.
  task automatic wr(input logic [4:0] a, input word_t d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    last_bresp = bresp;
    bready <= 1'b0;
  endtask : wr
  // One AXI4-Lite read, returning data and response.
  task automatic rd(input logic [4:0] a, output word_t d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  // Reads a register and compares the whole word.
  task automatic rdchk(input logic [4:0] a, input word_t e);
    word_t d;
    logic [1:0] r;
    rd(a, d, r);
    `CHK(d, e)
  endtask : rdchk
  // Polls the state until it matches or the tries run out.
  task automatic wait_st(input msm_state_e s);
    word_t d;
    logic [1:0] r;
    for (int k = 0; k < 80; k++) begin
      rd(`OFS_STATUS, d, r);
      if (d[2:0] === s) break;
    end
    `CHK(d[2:0], s)
  endtask : wait_st
  ////////////////////////////////////////////////////////////////////////
  // Boot to ready, interrupt masking, flag clearing, unmapped read.
  task automatic t_boot;
    word_t d;
    logic [1:0] r;
    wait_st(ready_state);
    `CHK(power_ctl.high_power_allowed, 1'b1)
    rdchk(`OFS_CONTROL, 32'h4);
    rdchk(`OFS_PATHS, 32'h1);
    `CHK(irq, 1'b1)
    wr(`OFS_MASK, 32'h1);
    `CHK(last_bresp, 2'h0)
    idle(2);
    `CHK(irq, 1'b0)
    wr(`OFS_MASK, 32'h0);
    idle(2);
    `CHK(irq, 1'b1)
    rdchk(`OFS_FLAGS, 32'h1);
    rdchk(`OFS_FLAGS, 32'h0);
    idle(2);
    `CHK(irq, 1'b0)
    rd(5'h14, d, r);
    `CHK(r, 2'h2)
    wr(5'h14, 32'h0);
    `CHK(last_bresp, 2'h2)
  endtask : t_boot
  // A low power pass that bounces straight back is not notified.
  task automatic t_suppress;
    wr(`OFS_CONTROL, 32'h6);
    wait_st(power_down_state);
    rdchk(`OFS_FLAGS, 32'h0);
    wr(`OFS_CONTROL, 32'h4);
    wait_st(power_up_state);
    rdchk(`OFS_FLAGS, 32'h0);
    wait_st(ready_state);
    rdchk(`OFS_FLAGS, 32'h1);
  endtask : t_suppress
  // Active lanes hold ready; then the low power truth table.
  task automatic t_lanes;
    @(posedge aclk);
    lanes_up <= 1'b1;
    wr(`OFS_CONTROL, 32'h6);
    idle(60);
    wait_st(ready_state);
    rdchk(`OFS_PATHS, 32'h0);
    lanes_up <= 1'b0;
    wait_st(low_power_state);
    `CHK(power_ctl, 3'h1)
    rdchk(`OFS_FLAGS, 32'h1);
    lp_pin <= 1'b1;
    idle(5);
    wr(`OFS_CONTROL, 32'h4);
    idle(60);
    wait_st(low_power_state);
    wr(`OFS_CONTROL, 32'h0);
    wait_st(ready_state);
    wr(`OFS_CONTROL, 32'h4);
    wait_st(low_power_state);
    lp_pin <= 1'b0;
    wait_st(ready_state);
    rdchk(`OFS_FLAGS, 32'h1);
  endtask : t_lanes
  // Fault entry, exit only by reset, reset sources and soft reset.
  task automatic t_fault;
    fault <= 1'b1;
    wait_st(fault_state);
    rdchk(`OFS_FLAGS, 32'h1);
    wr(`OFS_CONTROL, 32'h6);
    idle(40);
    wait_st(fault_state);
    wr(`OFS_CONTROL, 32'h4);
    reset_go <= 1'b1;
    @(posedge aclk);
    reset_go <= 1'b0;
    idle(60);
    `CHK(irq, 1'b1)
    supply_low <= 1'b1;
    wait_st(st_reset);
    `CHK(power_ctl, 3'h4)
    `CHK(irq, 1'b0)
    rdchk(`OFS_FLAGS, 32'h1);
    fault <= 1'b0;
    supply_low <= 1'b0;
    wait_st(ready_state);
    wr(`OFS_CONTROL, 32'hC);
    wait_st(fault_state);
    wr(`OFS_CONTROL, 32'h5);
    idle(2);
    wait_st(ready_state);
    rdchk(`OFS_CONTROL, 32'h4);
  endtask : t_fault
  ////////////////////////////////////////////////////////////////////////
  // Reset, then each scenario in turn.
  initial begin
    {aresetn, reset_go, supply_low, lp_pin, lanes_up, fault} <= 6'h0;
    {awvalid, wvalid, bready, arvalid, rready} <= 5'h0;
    {awaddr, araddr, wdata} <= 42'h0;
    wstrb <= 4'hF;
    idle(10);
    aresetn <= 1'b1;
    t_boot;
    t_suppress;
    t_lanes;
    t_fault;
    wrap_up;
  end
  // Cuts a hang short.
  initial begin
    idle(20000);
    num_errors++;
    wrap_up;
  end
endmodule : tb_top
